/* hdl/fcms_regs.vh */
// Purpose: constants for the flash command host controller
// Assumes: included by the controller files and by the self checking bench
// Notes: register offsets are byte addresses on the APB side
`ifndef FCMS_REGS_VH
`define FCMS_REGS_VH
// command codes written to the command interface
`define FCMS_CMD_READ_ARRAY 8'hff
`define FCMS_CMD_READ_ID 8'h90
`define FCMS_CMD_READ_STATUS 8'h70
`define FCMS_CMD_CLEAR_STATUS 8'h50
`define FCMS_CMD_PROG_SETUP 8'h40
`define FCMS_CMD_ERASE_SETUP 8'h20
`define FCMS_CMD_ERASE_CONFIRM 8'hd0
// apb register offsets
`define FCMS_OFF_CTRL 12'h000
`define FCMS_OFF_ADDR 12'h004
`define FCMS_OFF_WDATA 12'h008
`define FCMS_OFF_RDATA 12'h00c
`define FCMS_OFF_STATUS 12'h010
// ctrl fields: op code in [2:0], byte mode in bit 4
`define FCMS_CTRL_OP_LSB 0
`define FCMS_CTRL_OP_MSB 2
`define FCMS_CTRL_BYTE_BIT 4
// operations
`define FCMS_OP_READ 3'h0
`define FCMS_OP_CMD 3'h1
`define FCMS_OP_PROGRAM 3'h2
`define FCMS_OP_ERASE 3'h3
`define FCMS_OP_POLL 3'h4
`define FCMS_OP_RESET 3'h5
// status register bits of the device
`define FCMS_SR_READY 7
`define FCMS_SR_ERASE_ERR 5
`define FCMS_SR_PROG_ERR 4
`define FCMS_SR_VOLT_ERR 3
// timing, in ns, and derived cycles at 100 ns
`define FCMS_CLK_NS 100
`define FCMS_STROBE_NS 100
`define FCMS_STROBE_CYC ((`FCMS_STROBE_NS + `FCMS_CLK_NS - 1) / `FCMS_CLK_NS)
`define FCMS_RESET_NS 1000
`define FCMS_RESET_CYC ((`FCMS_RESET_NS + `FCMS_CLK_NS - 1) / `FCMS_CLK_NS)
`define FCMS_WAKE_NS 1000
`define FCMS_WAKE_CYC ((`FCMS_WAKE_NS + `FCMS_CLK_NS - 1) / `FCMS_CLK_NS)
`define FCMS_RESET_VAL 32'h00000000
`endif

/* hdl/fcms_sync.v */
// Purpose: two flop synchroniser for the flash data input bus
// Assumes: d arrives from outside the sys_clk domain
// Notes: the first stage is read only by the second
`timescale 1ns/1ps
`default_nettype none
module fcms_sync (
	input wire sys_clk,
	input wire reset,
	input wire [15:0] d,
	output reg [15:0] q
);
	reg [15:0] meta_q;

	always @(posedge sys_clk) begin
		if (reset) begin
			meta_q <= 16'h0000;
			q <= 16'h0000;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule
`default_nettype wire

/* hdl/fcms_host.v */
// Purpose: apb controlled host that drives a boot block flash by its pins
// Assumes: 10 mhz sys_clk, synchronous active high reset
// Notes: each strobe pulse lasts whole cycles, data sampled after sync
//
// Operation
// [R01] device starts in read array mode
// [R02] ffh selects array reads
// [R03] read array ignored while busy
// [R04] read array independent of program voltage
// [R05] 90h or high voltage enters identifier
// [R06] low address bit picks maker or part
// [R07] byte mode gives low identifier byte
// [R08] 70h selects status reads
// [R09] program or erase enters status mode
// [R10] status on low byte, upper zero
// [R11] status latched at later falling strobe
// [R12] toggle strobes between status reads
// [R13] error flags sticky until clear or reset
// [R14] 50h clears error flags
// [R15] clear ignored while erase suspended
// [R16] reset pin clears status
// [R17] program is 40h then address data
// [R18] ready flag marks program done
// [R19] voltage flag marks bad program voltage
// [R20] verify flags only failed zero bits
// [R21] erase is 20h then d0h in block
// [R22] erased block reads all ones
// [R23] bad erase confirm sets both errors
// [R24] after power down status is 80h
// [R25] write only with we ce low, oe high
// [R26] unknown codes leave state unchanged
//
// Local design decisions: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "fcms_regs.vh"
module fcms_host (
	input wire sys_clk,
	input wire reset,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	output reg ce_n,
	output reg oe_n,
	output reg we_n,
	output reg reset_powerdown_n,
	output reg byte_n,
	output reg [19:0] addr,
	output reg [15:0] dq_out,
	output reg dq_oe,
	input wire [15:0] dq_in
);
	// ------------------------------------------------------------
	// states
	// ------------------------------------------------------------
	localparam [3:0] S_IDLE = 4'h0;
	localparam [3:0] S_W1 = 4'h1;
	localparam [3:0] S_W1_END = 4'h2;
	localparam [3:0] S_W2 = 4'h3;
	localparam [3:0] S_W2_END = 4'h4;
	localparam [3:0] S_RD = 4'h5;
	localparam [3:0] S_RD_WAIT = 4'h6;
	localparam [3:0] S_RD_END = 4'h7;
	localparam [3:0] S_RST = 4'h8;
	localparam [3:0] S_WAKE = 4'h9;
	localparam integer STROBE_I = `FCMS_STROBE_CYC;
	localparam integer RESET_I = `FCMS_RESET_CYC;
	localparam integer WAKE_I = `FCMS_WAKE_CYC;
	localparam [7:0] STROBE_CYC = STROBE_I[7:0];
	localparam [7:0] RESET_CYC = RESET_I[7:0];
	localparam [7:0] WAKE_CYC = WAKE_I[7:0];

	reg [3:0] state_q;
	reg [7:0] cnt_q;
	reg [2:0] op_q;
	reg byte_mode_q;
	reg [19:0] addr_q;
	reg [15:0] wdata_q;
	reg [15:0] rdata_q;
	reg busy_q;
	reg done_q;
	reg polling_q;
	wire [15:0] dq_sync;

	// ------------------------------------------------------------
	// pin input sync
	// ------------------------------------------------------------
	fcms_sync u_sync (
		.sys_clk(sys_clk),
		.reset(reset),
		.d(dq_in),
		.q(dq_sync)
	);

	// ------------------------------------------------------------
	// apb slave: zero wait, errors never flagged
	// ------------------------------------------------------------
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	wire wr_en = psel & penable & pwrite;
	wire start = wr_en & (paddr == `FCMS_OFF_CTRL) & ~busy_q;

	always @* begin
		case (paddr)
		`FCMS_OFF_CTRL: prdata = {27'h0000000, byte_mode_q, 1'b0, op_q};
		`FCMS_OFF_ADDR: prdata = {12'h000, addr_q};
		`FCMS_OFF_WDATA: prdata = {16'h0000, wdata_q};
		`FCMS_OFF_RDATA: prdata = {16'h0000, rdata_q};
		`FCMS_OFF_STATUS: prdata = {30'h00000000, done_q, busy_q};
		default: prdata = 32'h00000000;
		endcase
	end

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	always @(posedge sys_clk) begin
		if (reset) begin
			state_q <= S_IDLE;
			cnt_q <= 8'h00;
			op_q <= `FCMS_OP_READ;
			byte_mode_q <= 1'b0;
			addr_q <= 20'h00000;
			wdata_q <= 16'h0000;
			rdata_q <= 16'h0000;
			busy_q <= 1'b0;
			done_q <= 1'b0;
			polling_q <= 1'b0;
			ce_n <= 1'b1;
			oe_n <= 1'b1;
			we_n <= 1'b1;
			reset_powerdown_n <= 1'b0;
			byte_n <= 1'b1;
			addr <= 20'h00000;
			dq_out <= 16'h0000;
			dq_oe <= 1'b0;
		end else begin
			byte_n <= ~byte_mode_q;
			if (wr_en && paddr == `FCMS_OFF_ADDR && !busy_q)
				addr_q <= pwdata[19:0];
			if (wr_en && paddr == `FCMS_OFF_WDATA && !busy_q)
				wdata_q <= pwdata[15:0];
			if (wr_en && paddr == `FCMS_OFF_STATUS)
				done_q <= 1'b0;
			case (state_q)
			S_IDLE: begin
				// release from reset pin low, so the device enters array mode
				if (!reset_powerdown_n) begin // [R01] [R16] [R24]
					state_q <= S_WAKE;
					reset_powerdown_n <= 1'b1;
					cnt_q <= WAKE_CYC;
					busy_q <= 1'b1;
				end else if (start) begin
					op_q <= pwdata[`FCMS_CTRL_OP_MSB:`FCMS_CTRL_OP_LSB];
					byte_mode_q <= pwdata[`FCMS_CTRL_BYTE_BIT];
					busy_q <= 1'b1;
					done_q <= 1'b0;
					cnt_q <= STROBE_CYC;
					case (pwdata[`FCMS_CTRL_OP_MSB:`FCMS_CTRL_OP_LSB])
					`FCMS_OP_READ: state_q <= S_RD; // [R02]
					`FCMS_OP_POLL: begin
						polling_q <= 1'b1;
						state_q <= S_RD;
					end
					`FCMS_OP_RESET: begin
						reset_powerdown_n <= 1'b0; // [R16]
						cnt_q <= RESET_CYC;
						state_q <= S_RST;
					end
					`FCMS_OP_CMD: begin
						// raw command: ff, 90, 70, 50 and others
						dq_out <= {8'h00, wdata_q[7:0]}; // [R05] [R08] [R14]
						addr <= addr_q;
						state_q <= S_W1;
					end
					`FCMS_OP_PROGRAM: begin
						dq_out <= {8'h00, `FCMS_CMD_PROG_SETUP}; // [R17]
						addr <= addr_q;
						state_q <= S_W1;
					end
					`FCMS_OP_ERASE: begin
						dq_out <= {8'h00, `FCMS_CMD_ERASE_SETUP}; // [R21]
						addr <= addr_q;
						state_q <= S_W1;
					end
					default: begin
						busy_q <= 1'b0;
						state_q <= S_IDLE;
					end
					endcase
					if (pwdata[`FCMS_CTRL_OP_MSB:`FCMS_CTRL_OP_LSB] ==
					    `FCMS_OP_CMD ||
					    pwdata[`FCMS_CTRL_OP_MSB:`FCMS_CTRL_OP_LSB] ==
					    `FCMS_OP_PROGRAM ||
					    pwdata[`FCMS_CTRL_OP_MSB:`FCMS_CTRL_OP_LSB] ==
					    `FCMS_OP_ERASE) begin
						// oe stays high through every write strobe
						oe_n <= 1'b1; // [R25]
						ce_n <= 1'b0;
						we_n <= 1'b0;
						dq_oe <= 1'b1;
					end
				end
			end
			S_W1, S_W2: begin
				if (cnt_q > 8'h01) begin
					cnt_q <= cnt_q - 8'h01;
				end else begin
					// we rises first; address and data held past it
					we_n <= 1'b1; // [R25]
					state_q <= (state_q == S_W1) ? S_W1_END : S_W2_END;
				end
			end
			S_W1_END: begin
				ce_n <= 1'b1;
				dq_oe <= 1'b0;
				if (op_q == `FCMS_OP_CMD) begin
					busy_q <= 1'b0;
					done_q <= 1'b1;
					state_q <= S_IDLE;
				end else begin
					// second cycle: data, or confirm code at block address
					if (op_q == `FCMS_OP_PROGRAM)
						dq_out <= wdata_q; // [R17]
					else
						dq_out <= {8'h00, `FCMS_CMD_ERASE_CONFIRM}; // [R21]
					state_q <= S_W2;
					cnt_q <= STROBE_CYC;
					ce_n <= 1'b0;
					we_n <= 1'b0;
					dq_oe <= 1'b1;
				end
			end
			S_W2_END: begin
				ce_n <= 1'b1;
				dq_oe <= 1'b0;
				// device now in status mode; poll until ready
				polling_q <= 1'b1; // [R09]
				cnt_q <= STROBE_CYC;
				state_q <= S_RD;
			end
			S_RD: begin
				// fresh ce and oe fall for each read, status latched then
				ce_n <= 1'b0; // [R11] [R12]
				oe_n <= 1'b0;
				addr <= addr_q;
				cnt_q <= STROBE_CYC + 8'h02;
				state_q <= S_RD_WAIT;
			end
			S_RD_WAIT: begin
				if (cnt_q > 8'h01) begin
					cnt_q <= cnt_q - 8'h01;
				end else begin
					rdata_q <= byte_mode_q ? {8'h00, dq_sync[7:0]} :
						dq_sync; // [R07] [R10]
					ce_n <= 1'b1;
					oe_n <= 1'b1;
					state_q <= S_RD_END;
				end
			end
			S_RD_END: begin
				// ready bit low: read again after strobes went high
				if (polling_q && !rdata_q[`FCMS_SR_READY]) begin // [R18]
					state_q <= S_RD;
				end else begin
					polling_q <= 1'b0;
					busy_q <= 1'b0;
					done_q <= 1'b1;
					state_q <= S_IDLE;
				end
			end
			S_RST: begin
				if (cnt_q > 8'h01)
					cnt_q <= cnt_q - 8'h01;
				else begin
					reset_powerdown_n <= 1'b1;
					cnt_q <= WAKE_CYC;
					state_q <= S_WAKE;
				end
			end
			S_WAKE: begin
				if (cnt_q > 8'h01)
					cnt_q <= cnt_q - 8'h01;
				else begin
					busy_q <= 1'b0;
					done_q <= 1'b1;
					state_q <= S_IDLE;
				end
			end
			default: state_q <= S_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

/* bench/fcms_host_monitor.sv */
// Purpose: pin protocol checks on the flash host
// Assumes: strobes and data are registered on sys_clk
// Notes: only the flash side pins are watched
`timescale 1ns/1ps
`default_nettype none
module fcms_mon (
	input wire sys_clk,
	input wire reset,
	input wire ce_n,
	input wire oe_n,
	input wire we_n,
	input wire reset_powerdown_n,
	input wire dq_oe,
	input wire [19:0] addr,
	input wire [15:0] dq_out
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	// ce may stay low when the second write strobe of a pair follows
	sequence s_write;
		!we_n ##1 we_n && !ce_n && oe_n ##1 (ce_n || !we_n);
	endsequence
	sequence s_read;
		!oe_n [*2] ##[1:6] oe_n;
	endsequence
	a_write_legal: assert property (!we_n |-> !ce_n && oe_n && dq_oe)
		else $error("write strobe out of place");
	a_read_legal: assert property (!oe_n |-> we_n && !ce_n && !dq_oe)
		else $error("read strobe out of place");
	a_write_cycle: assert property ($fell(we_n) |-> s_write)
		else $error("bad write cycle");
	a_cmd_held: assert property ($rose(we_n) |-> $stable(dq_out)
		&& $stable(addr))
		else $error("data moved at write edge");
	a_read_cycle: assert property ($fell(oe_n) |-> s_read)
		else $error("bad read cycle");
	a_status_toggle: assert property ($rose(oe_n) |-> $rose(ce_n))
		else $error("strobes not released together");
	a_reset_pin: assert property (@(posedge sys_clk) disable iff (1'b0)
		reset |=> !reset_powerdown_n && ce_n && !dq_oe)
		else $error("pins not quiet in reset");
	a_rp_pulse: assert property ($fell(reset_powerdown_n)
		|-> !reset_powerdown_n [*8])
		else $error("reset pulse too short");
endmodule
bind fcms_host fcms_mon mon (.sys_clk(sys_clk), .reset(reset),
	.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .dq_oe(dq_oe),
	.reset_powerdown_n(reset_powerdown_n), .addr(addr), .dq_out(dq_out));
`default_nettype wire

/* bench/fcms_flash.sv */
// Purpose: behavioural flash on the host pins
// Assumes: sys_clk only times the busy interval
// Notes: one 16 word block, no suspend, no program voltage
`timescale 1ns/1ps
`default_nettype none
module fcms_flash #(
	parameter BUSY = 20,
	parameter [15:0] MFR = 16'ha55a, // arbitrary value
	parameter [15:0] DEV = 16'h3cc3 // arbitrary value
) (
	input wire sys_clk,
	input wire ce_n,
	input wire oe_n,
	input wire we_n,
	input wire rp_n,
	input wire byte_n,
	input wire [19:0] addr,
	input wire [15:0] d,
	output wire [15:0] q
);
	reg [15:0] mem [0:15];
	reg [1:0] mode = 0;
	reg [1:0] nxt = 0;
	reg [7:0] srl = 0;
	reg ee = 0;
	reg pe = 0;
	integer bsy = 0;
	reg go_t = 0;
	reg go_s = 0;
	integer i;
	wire [3:0] a = addr[3:0];
	wire [15:0] v = mode == 2 ? {8'h00, srl} : mode == 1 ?
		(addr[0] ? DEV : MFR) : mem[a];
	wire [15:0] rv = {byte_n ? v[15:8] : ~v[15:8], v[7:0]};
	// released bus shows the inverse, never a stale match
	assign q = !ce_n && !oe_n ? rv : ~rv;
	initial for (i = 0; i < 16; i = i + 1) mem[i] = 16'hc3c0 | i;
	// busy count lives in the clock domain; the write strobe only flips
	// a toggle, so a single process drives the count
	always @(posedge sys_clk)
		if (!rp_n) begin
			bsy <= 0;
			go_s <= go_t;
		end else if (go_s != go_t) begin
			go_s <= go_t;
			bsy <= BUSY;
		end else if (bsy > 0)
			bsy <= bsy - 1;
	// voltage flag in bit 3 stays low: the model's supply is always valid
	always @(negedge oe_n or negedge ce_n)
		if (!oe_n && !ce_n) srl <= {bsy == 0, 1'b0, ee, pe, 4'h0};
	always @(posedge we_n or negedge rp_n)
		if (!rp_n) begin
			mode <= 0;
			nxt <= 0;
			ee <= 0;
			pe <= 0;
		end else if (!ce_n && oe_n && bsy == 0) begin
			nxt <= 0;
			if (nxt == 1) begin
				mem[a] <= mem[a] & d;
				go_t <= ~go_t;
				mode <= 2;
			end else if (nxt == 2) begin
				mode <= 2;
				if (d[7:0] == 8'hd0) begin
					for (i = 0; i < 16; i = i + 1) mem[i] <= 16'hffff;
					go_t <= ~go_t;
				end else begin
					ee <= 1;
					pe <= 1;
				end
			end else case (d[7:0])
				8'hff: mode <= 0;
				8'h90: mode <= 1;
				8'h70: mode <= 2;
				8'h50: {ee, pe} <= 0;
				8'h40: nxt <= 1;
				8'h20: nxt <= 2;
				default: ;
			endcase
		end
endmodule
`default_nettype wire

/* bench/test_fcms_host.sv */
// Purpose: self checking bench for the flash host
// Assumes: fcms_flash on the pins, apb with pready
// Notes: flash busy time cut short by a parameter
`timescale 1ns/1ps
`default_nettype none
`include "fcms_regs.vh"
module test_fcms_host;
	reg sys_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, bm = 0;
	reg [11:0] paddr = 0;
	reg [31:0] pwdata = 0, r;
	wire [31:0] prdata;
	wire pready, pslverr, ce_n, oe_n, we_n, rp_n, byte_n, dq_oe;
	wire [19:0] addr;
	wire [15:0] dq_out, dq_in;
	integer mismatches = 0, n_checks = 0;
	always #50 sys_clk = ~sys_clk;
	fcms_host DUT (.sys_clk(sys_clk), .reset(reset), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .ce_n(ce_n),
		.oe_n(oe_n), .we_n(we_n), .reset_powerdown_n(rp_n), .byte_n(byte_n),
		.addr(addr), .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in));
	fcms_flash #(.BUSY(20)) flash (.sys_clk(sys_clk), .ce_n(ce_n),
		.oe_n(oe_n), .we_n(we_n), .rp_n(rp_n), .byte_n(byte_n),
		.addr(addr), .d(dq_out), .q(dq_in));
	task chk(input [31:0] g, input [31:0] e);
		n_checks = n_checks + 1;
		if (g !== e) begin
			mismatches = mismatches + 1;
			$display("ERROR t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task apb(input w, input [11:0] a, input [31:0] d);
		@(posedge sys_clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1;
		@(posedge sys_clk);
		while (pready !== 1'b1) @(posedge sys_clk);
		r = prdata;
		psel <= 0;
		penable <= 0;
	endtask
	task idle;
		integer i;
		for (i = 0; i < 400; i = i + 1) begin
			apb(0, `FCMS_OFF_STATUS, 0);
			if (r[1:0] === 2'b10) i = 400;
		end
		// a wait that runs out shows up here as a mismatch
		chk({30'h0, r[1:0]}, 32'h00000002);
	endtask
	task run(input [2:0] o);
		apb(1, `FCMS_OFF_CTRL, {27'h0, bm, 1'b0, o});
		idle;
	endtask
	task cmd(input [7:0] c);
		apb(1, `FCMS_OFF_WDATA, {24'h0, c});
		run(`FCMS_OP_CMD);
	endtask
	task rd(input [19:0] a, input [31:0] e);
		apb(1, `FCMS_OFF_ADDR, {12'h0, a});
		run(`FCMS_OP_READ);
		apb(0, `FCMS_OFF_RDATA, 0);
		chk(r, e);
	endtask
	task t_boot;
		rd(3, 32'hc3c3);
		apb(0, 12'h020, 0);
		chk({31'h0, pslverr}, 0);
	endtask
	task t_ident;
		cmd(`FCMS_CMD_READ_ID);
		rd(0, 32'ha55a);
		rd(1, 32'h3cc3);
		bm = 1;
		rd(3, 32'hc3);
		bm = 0;
		cmd(`FCMS_CMD_READ_ARRAY);
		rd(1, 32'hc3c1);
	endtask
	task t_prog;
		apb(1, `FCMS_OFF_ADDR, 5);
		apb(1, `FCMS_OFF_WDATA, 32'hff0f);
		run(`FCMS_OP_PROGRAM);
		rd(9, 32'h80);
		run(`FCMS_OP_POLL);
		apb(0, `FCMS_OFF_RDATA, 0);
		chk(r, 32'h80);
		cmd(`FCMS_CMD_READ_ARRAY);
		rd(5, 32'hc305);
	endtask
	task t_errors;
		cmd(`FCMS_CMD_ERASE_SETUP);
		cmd(8'h00);
		rd(0, 32'hb0);
		cmd(8'h00);
		rd(0, 32'hb0);
		cmd(`FCMS_CMD_READ_ARRAY);
		rd(0, 32'hc3c0);
		cmd(`FCMS_CMD_READ_STATUS);
		rd(0, 32'hb0);
		cmd(`FCMS_CMD_CLEAR_STATUS);
		rd(0, 32'h80);
		cmd(`FCMS_CMD_ERASE_SETUP);
		cmd(8'h00);
		run(`FCMS_OP_RESET);
		rd(1, 32'hc3c1);
		cmd(`FCMS_CMD_READ_STATUS);
		rd(1, 32'h80);
	endtask
	task t_erase;
		apb(1, `FCMS_OFF_ADDR, 2);
		run(`FCMS_OP_ERASE);
		rd(2, 32'h80);
		cmd(`FCMS_CMD_READ_ARRAY);
		rd(5, 32'hffff);
	endtask
	task finish_test;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge sys_clk);
		reset <= 0;
		idle;
		t_boot;
		t_ident;
		t_prog;
		t_errors;
		t_erase;
		finish_test;
	end
	initial begin
		#3000000;
		mismatches = mismatches + 1;
		finish_test;
	end
endmodule
`default_nettype wire
